// ===== audio_serial_pkg.sv
// package: constants, modes and carriers of the serial audio port and its processing path
package audio_serial_pkg;

    // ------------------------------------------------------------------
    // modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {fmt_standard, fmt_left_justified, fmt_right_justified} framing_e;
    typedef enum logic [1:0] {width_16, width_20, width_24, width_32} sample_width_e;
    typedef enum logic [1:0] {slot_len_16, slot_len_24, slot_len_32} slot_len_e;
    typedef enum logic [1:0] {chan_left, chan_right, chan_average} source_chan_e;
    typedef enum logic [2:0] {slots_1, slots_2, slots_4, slots_6, slots_8} slot_count_e;

    // ------------------------------------------------------------------
    // numbers
    // ------------------------------------------------------------------
    localparam int EQ_SECTIONS = 10;
    localparam int BANDS = 3;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] BITS_32 = 6'h20;
    localparam logic [3:0] SLOTS_1 = 4'h1;
    localparam logic [3:0] SLOTS_2 = 4'h2;
    localparam logic [3:0] SLOTS_4 = 4'h4;
    localparam logic [3:0] SLOTS_6 = 4'h6;
    localparam logic [3:0] SLOTS_8 = 4'h8;
    localparam logic signed [6:0] STD_MSB_OFFSET = 7'sh01;
    localparam logic [9:0] VOL_ATTEN_MAX = 10'h2FF;
    localparam logic [9:0] VOL_STEPS_PER_HALF = 10'h030;
    localparam logic [15:0] VOL_MANT_STEP = 16'h02AB;
    localparam logic [15:0] AGC_UNITY = 16'h8000;
    localparam int AGC_DECAY_SHIFT = 6;
    localparam int EQ_FRAC_BITS = 14;
    localparam int DC_SHIFT_DEFAULT = 10;
    localparam int LOW_BAND_SHIFT = 3;
    localparam int MID_BAND_SHIFT = 1;
    localparam int EXCURSION_SHIFT = 4;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        framing_e framing_format_select;
        logic tdm_mode;
        slot_count_e slot_count_select;
        sample_width_e sample_width_select;
        slot_len_e slot_length_select;
        source_chan_e source_channel_select;
        logic input_half_level;
        logic tx_output_enable;
        logic unused_slot_tristate;
        logic unused_slot_fill_select;
        logic [2:0] tx_slot;
    } port_cfg_s;

    typedef struct packed {
        logic [9:0] volume_atten;
        logic mute;
        logic [23:0] agc_threshold;
        logic [23:0] limiter_level;
        logic [23:0] excursion_threshold;
        logic [23:0] power_threshold;
        logic [7:0] attack_samples;
        logic [7:0] release_samples;
        logic [15:0] coil_temp;
        logic [15:0] coil_temp_threshold;
        logic [BANDS-1:0][23:0] band_threshold;
        logic [BANDS-1:0][2:0] band_ratio_shift;
        logic [EQ_SECTIONS-1:0][2:0][15:0] eq_coef;
    } dsp_cfg_s;

    typedef struct packed {
        logic bclk_s1, bclk_s2, bclk_d, wck_s1, wck_s2, rx_s1, rx_s2, wck_prev;
        logic [5:0] bis;
        logic [3:0] slot;
        logic [31:0] shift;
        logic [23:0] left, right;
        logic pending;
        logic [31:0] dc_est;
        logic [15:0] agc_gain;
        logic [EQ_SECTIONS-1:0][23:0] eq_x1, eq_y1;
        logic [23:0] lp1, lp2, exc_lp;
        logic pwr_att;
        logic [7:0] pwr_cnt;
        logic [23:0] result;
        logic result_valid;
        logic [23:0] tx_word;
        logic [23:0] d0, d1;
        logic v0, v1;
        logic tx_bit, tx_oe, overrun;
    } state_s;

    // the bit clock idles high, so its synchronisers start high and no false rise follows reset
    localparam state_s STATE_RESET = '{agc_gain: AGC_UNITY, bclk_s1: 1'b1, bclk_s2: 1'b1,
                                       bclk_d: 1'b1, default: '0};

endpackage

// ===== audio_serial_port_and_dsp_path.sv
// module: serial audio slave port, processing chain, two-entry output buffer
`timescale 1ns/1ps
`default_nettype none
module audio_serial_port_and_dsp_path
    import audio_serial_pkg::*;
#(
    parameter int DC_SHIFT = DC_SHIFT_DEFAULT
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // serial pins
    input wire logic bit_clock,
    input wire logic frame_word_clock,
    input wire logic serial_rx_data,
    output logic serial_tx_data,
    output logic serial_tx_data_oe,
    // configuration
    input wire audio_serial_pkg::port_cfg_s port_cfg,
    input wire audio_serial_pkg::dsp_cfg_s dsp_cfg,
    // processed samples
    output logic [23:0] sample_out,
    output logic sample_out_valid,
    input wire logic sample_out_ready,
    output logic rx_overrun
);
    import audio_serial_pkg::*;

    state_s st_reg, st_next;
    logic rise, fall, fstart, process;
    logic [5:0] slen, wbits;
    logic [3:0] nslots;
    logic signed [6:0] start_off, pos, tx_pos;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [23:0] sat(input logic signed [47:0] v);
        if (v > 48'sh0000007FFFFF)
            sat = 24'h7FFFFF;
        else if (v < 48'shFFFFFF800000)
            sat = 24'h800000;
        else
            sat = v[23:0];
    endfunction

    function automatic logic [23:0] mag(input logic [23:0] v);
        mag = v[23] ? 24'(-$signed(v)) : v;
    endfunction

    // a band above its threshold keeps only a shifted share of the excess
    function automatic logic [23:0] comp(input logic [23:0] v, input logic [23:0] thr,
                                         input logic [2:0] sh);
        logic [23:0] m;
        logic [23:0] o;
        m = mag(v);
        o = thr + ((m - thr) >> sh);
        if (m > thr)
            comp = v[23] ? 24'(-$signed(o)) : o;
        else
            comp = v;
    endfunction

    // ------------------------------------------------------------------
    // framing geometry
    // ------------------------------------------------------------------
    always_comb
    begin
        case (port_cfg.slot_length_select)
            slot_len_16: slen = BITS_16;
            slot_len_24: slen = BITS_24;
            default: slen = BITS_32;
        endcase
        case (port_cfg.sample_width_select)
            width_16: wbits = BITS_16;
            width_20: wbits = BITS_20;
            width_24: wbits = BITS_24;
            default: wbits = BITS_32;
        endcase
        // two-slot mode forces a pair of slots whatever the count field says
        case (port_cfg.slot_count_select)
            slots_1: nslots = SLOTS_1;
            slots_2: nslots = SLOTS_2;
            slots_4: nslots = SLOTS_4;
            slots_6: nslots = SLOTS_6;
            default: nslots = SLOTS_8;
        endcase
        if (!port_cfg.tdm_mode)
            nslots = SLOTS_2;
        // first data bit position within a slot, same for every slot count
        case (port_cfg.framing_format_select)
            fmt_standard: start_off = 7'sh00; // the grid itself lags one bit
            fmt_left_justified: start_off = 7'sh00;
            default: start_off = (slen > wbits) ? $signed({1'b0, slen - wbits}) : 7'sh00;
        endcase
    end

    // bit clock edges found on the synchronised copy
    assign rise = st_reg.bclk_s2 && !st_reg.bclk_d;
    assign fall = !st_reg.bclk_s2 && st_reg.bclk_d;
    // only the edge matters, so a one-bit or one-slot sync pulse both work
    assign fstart = rise && ((port_cfg.framing_format_select == fmt_standard && !port_cfg.tdm_mode)
                    ? (st_reg.wck_prev && !st_reg.wck_s2)
                    : (!st_reg.wck_prev && st_reg.wck_s2));
    assign process = st_reg.pending && !st_reg.result_valid;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [31:0] word;
        logic [5:0] nb;
        logic [3:0] ns;
        logic [23:0] src, s, lo, md, hi, m;
        logic signed [47:0] y, t;
        logic [9:0] v, vsh;
        logic [15:0] mant;
        logic over;
        logic [7:0] cnt1;
        word = '0;
        nb = '0;
        ns = '0;
        src = '0;
        s = '0;
        lo = '0;
        md = '0;
        hi = '0;
        m = '0;
        y = '0;
        t = '0;
        v = '0;
        vsh = '0;
        mant = '0;
        over = 1'b0;
        cnt1 = '0;
        tx_pos = '0;
        pos = '0;
        st_next = st_reg;
        st_next.overrun = 1'b0;
        // two-flop synchronisers; the first stage feeds only the second
        st_next.bclk_s1 = bit_clock;
        st_next.bclk_s2 = st_reg.bclk_s1;
        st_next.bclk_d = st_reg.bclk_s2;
        st_next.wck_s1 = frame_word_clock;
        st_next.wck_s2 = st_reg.wck_s1;
        st_next.rx_s1 = serial_rx_data;
        st_next.rx_s2 = st_reg.rx_s1;

        // receive on rising edges
        if (rise)
        begin
            st_next.wck_prev = st_reg.wck_s2;
            if (fstart)
            begin
                st_next.bis = '0;
                st_next.slot = '0;
                // standard framing parks one bit before slot 0, so its MSB lands a rise later
                if (port_cfg.framing_format_select == fmt_standard)
                begin
                    st_next.bis = slen - 6'(STD_MSB_OFFSET);
                    st_next.slot = 4'hF;
                end
            end
            // >= so that a shorter slot length set between frames cannot run the count away
            else if (st_reg.bis >= slen - 6'h01)
            begin
                st_next.bis = '0;
                st_next.slot = st_reg.slot + 4'h1;
            end
            else
                st_next.bis = st_reg.bis + 6'h01;
            // the bit under this rise sits where the counter now points
            pos = $signed({1'b0, st_next.bis}) - start_off;
            // bits outside the width window never reach the shifter
            if (pos >= 7'sh00 && pos < $signed({1'b0, wbits}) && st_next.slot < nslots)
            begin
                word = {st_reg.shift[30:0], st_reg.rx_s2};
                st_next.shift = word;
                if (pos == $signed({1'b0, wbits - 6'h01}))
                begin
                    word = word << (6'h20 - wbits);
                    if (st_next.slot == 4'h0)
                    begin
                        st_next.left = word[31:8];
                        if (nslots == SLOTS_1)
                            st_next.right = word[31:8];
                    end
                    if (st_next.slot == 4'h1)
                        st_next.right = word[31:8];
                    if (st_next.slot == ((nslots == SLOTS_1) ? 4'h0 : 4'h1))
                    begin
                        st_next.overrun = st_reg.pending;
                        st_next.pending = 1'b1;
                    end
                end
            end
        end

        // launch on falling edges for the position of the next rise
        if (fall)
        begin
            nb = st_reg.bis + 6'h01;
            ns = st_reg.slot;
            if (st_reg.bis >= slen - 6'h01)
            begin
                nb = '0;
                ns = st_reg.slot + 4'h1;
            end
            if (ns >= nslots)
                ns = '0;
            tx_pos = $signed({1'b0, nb}) - start_off;
            st_next.tx_bit = 1'b0;
            if (tx_pos >= 7'sh00 && tx_pos < $signed({1'b0, wbits}))
                st_next.tx_bit = st_reg.tx_word[5'(7'sd23 - tx_pos)];
            if (tx_pos > 7'sh17)
                st_next.tx_bit = 1'b0;
            st_next.tx_oe = 1'b1;
            if (ns != {1'b0, port_cfg.tx_slot})
            begin
                st_next.tx_oe = !port_cfg.unused_slot_tristate;
                if (!port_cfg.unused_slot_fill_select)
                    st_next.tx_bit = 1'b0;
            end
        end
        if (!port_cfg.tx_output_enable)
            st_next.tx_oe = 1'b0;

        // processing chain, one sample per frame
        if (process)
        begin
            case (port_cfg.source_channel_select)
                chan_left: src = st_reg.left;
                chan_right: src = st_reg.right;
                default: src = 24'((48'($signed(st_reg.left)) + 48'($signed(st_reg.right))) >>> 1);
            endcase
            if (port_cfg.input_half_level)
                src = $signed(src) >>> 1;
            y = 48'($signed(src)) - 48'($signed(st_reg.dc_est) >>> 8);
            st_next.dc_est = st_reg.dc_est + 32'(((48'($signed(src)) <<< 8)
                             - 48'($signed(st_reg.dc_est))) >>> DC_SHIFT);
            s = sat(y);
            // gain only drops while over threshold and creeps back to unity below it
            if (mag(s) > dsp_cfg.agc_threshold)
                st_next.agc_gain = st_reg.agc_gain - (st_reg.agc_gain >> AGC_DECAY_SHIFT);
            else if (st_reg.agc_gain < AGC_UNITY)
                st_next.agc_gain = st_reg.agc_gain + 16'h0001;
            y = (48'($signed(s)) * 48'($signed({1'b0, st_reg.agc_gain}))) >>> 15;
            for (int k = 0; k < EQ_SECTIONS; k++)
            begin
                s = sat(y);
                t = 48'($signed(s)) * 48'($signed(dsp_cfg.eq_coef[k][0]))
                    + 48'($signed(st_reg.eq_x1[k])) * 48'($signed(dsp_cfg.eq_coef[k][1]))
                    - 48'($signed(st_reg.eq_y1[k])) * 48'($signed(dsp_cfg.eq_coef[k][2]));
                y = t >>> EQ_FRAC_BITS;
                st_next.eq_x1[k] = s;
                st_next.eq_y1[k] = sat(y);
            end
            s = sat(y);
            st_next.lp1 = 24'(48'($signed(st_reg.lp1))
                          + ((48'($signed(s)) - 48'($signed(st_reg.lp1))) >>> LOW_BAND_SHIFT));
            st_next.lp2 = 24'(48'($signed(st_reg.lp2))
                          + ((48'($signed(s)) - 48'($signed(st_reg.lp2))) >>> MID_BAND_SHIFT));
            lo = comp(st_next.lp1, dsp_cfg.band_threshold[0], dsp_cfg.band_ratio_shift[0]);
            md = comp(sat(48'($signed(st_next.lp2)) - 48'($signed(st_next.lp1))),
                      dsp_cfg.band_threshold[1], dsp_cfg.band_ratio_shift[1]);
            hi = comp(sat(48'($signed(s)) - 48'($signed(st_next.lp2))),
                      dsp_cfg.band_threshold[2], dsp_cfg.band_ratio_shift[2]);
            y = 48'($signed(lo)) + 48'($signed(md)) + 48'($signed(hi));
            s = sat(y);
            // hard ceiling at the clip level, nothing past it reaches the output
            if (mag(s) > dsp_cfg.limiter_level)
                s = s[23] ? 24'(-$signed(dsp_cfg.limiter_level)) : dsp_cfg.limiter_level;
            st_next.exc_lp = 24'(48'($signed(st_reg.exc_lp))
                             + ((48'($signed(s)) - 48'($signed(st_reg.exc_lp))) >>> EXCURSION_SHIFT));
            if (mag(st_next.exc_lp) > dsp_cfg.excursion_threshold)
                s = $signed(s) >>> 1;
            over = mag(s) > dsp_cfg.power_threshold;
            cnt1 = st_reg.pwr_cnt + 8'h01;
            st_next.pwr_cnt = '0;
            if (over != st_reg.pwr_att)
            begin
                st_next.pwr_cnt = cnt1;
                if (cnt1 >= (over ? dsp_cfg.attack_samples : dsp_cfg.release_samples))
                begin
                    st_next.pwr_att = over;
                    st_next.pwr_cnt = '0;
                end
            end
            if (st_next.pwr_att)
                s = $signed(s) >>> 1;
            if (dsp_cfg.coil_temp >= dsp_cfg.coil_temp_threshold)
                s = $signed(s) >>> 1;
            // 48 steps per 6 dB: whole halvings by shift, the rest by a linear mantissa
            v = (dsp_cfg.volume_atten > VOL_ATTEN_MAX) ? VOL_ATTEN_MAX : dsp_cfg.volume_atten;
            vsh = v / VOL_STEPS_PER_HALF;
            mant = 16'hFFFF - 16'(16'(v - vsh * VOL_STEPS_PER_HALF) * VOL_MANT_STEP);
            y = ((48'($signed(s)) * 48'($signed({1'b0, mant}))) >>> 16) >>> vsh;
            s = sat(y);
            if (dsp_cfg.mute)
                s = '0;
            st_next.result = s;
            st_next.tx_word = s;
            st_next.result_valid = 1'b1;
            st_next.pending = 1'b0;
        end

        // two-entry buffer: the held result stalls the chain until there is room
        if (st_reg.v0 && sample_out_ready)
        begin
            st_next.d0 = st_reg.d1;
            st_next.v0 = st_reg.v1;
            st_next.v1 = 1'b0;
        end
        if (st_reg.result_valid && !(st_reg.v1 && st_next.v1))
        begin
            st_next.result_valid = 1'b0;
            if (!st_next.v0)
            begin
                st_next.d0 = st_reg.result;
                st_next.v0 = 1'b1;
            end
            else
            begin
                st_next.d1 = st_reg.result;
                st_next.v1 = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_reg <= STATE_RESET;
        else
            st_reg <= st_next;
    end

    assign serial_tx_data = st_reg.tx_bit;
    assign serial_tx_data_oe = st_reg.tx_oe;
    assign sample_out = st_reg.d0;
    assign sample_out_valid = st_reg.v0;
    assign rx_overrun = st_reg.overrun;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_tx_disabled;
        @(posedge ref_clk) disable iff (srst)
        !port_cfg.tx_output_enable |=> !serial_tx_data_oe;
    endproperty
    a_tx_disabled: assert property (p_tx_disabled) else $error("tx driven while disabled");

    property p_unused_tristate;
        @(posedge ref_clk) disable iff (srst)
        fall && port_cfg.unused_slot_tristate && port_cfg.tx_output_enable
        && st_reg.slot < nslots && st_reg.slot != {1'b0, port_cfg.tx_slot}
        && st_reg.bis < slen - 6'h01 |=> !serial_tx_data_oe;
    endproperty
    a_unused_tristate: assert property (p_unused_tristate) else $error("unused slot not released");

    property p_unused_zero;
        @(posedge ref_clk) disable iff (srst)
        fall && port_cfg.tx_output_enable && !port_cfg.unused_slot_tristate
        && !port_cfg.unused_slot_fill_select && st_reg.slot < nslots
        && st_reg.slot != {1'b0, port_cfg.tx_slot} && st_reg.bis < slen - 6'h01
        |=> serial_tx_data_oe && !serial_tx_data;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused slot not zero");

    property p_mute;
        @(posedge ref_clk) disable iff (srst)
        process && dsp_cfg.mute |=> st_reg.result == 24'h000000 && st_reg.result_valid;
    endproperty
    a_mute: assert property (p_mute) else $error("muted sample not silent");

    property p_limit;
        @(posedge ref_clk) disable iff (srst)
        process |=> mag(st_reg.result) <= $past(dsp_cfg.limiter_level);
    endproperty
    a_limit: assert property (p_limit) else $error("output above clip level");

    property p_shift_on_rise;
        @(posedge ref_clk) disable iff (srst)
        $changed(st_reg.shift) |-> $past(rise);
    endproperty
    a_shift_on_rise: assert property (p_shift_on_rise) else $error("capture off a rise");

    property p_launch_on_fall;
        @(posedge ref_clk) disable iff (srst)
        $rose(serial_tx_data_oe) |-> $past(fall);
    endproperty
    a_launch_on_fall: assert property (p_launch_on_fall) else $error("launch off a fall");

    property p_slot_bits;
        @(posedge ref_clk) disable iff (srst)
        rise ##1 !$changed(slen) |-> st_reg.bis < slen;
    endproperty
    a_slot_bits: assert property (p_slot_bits) else $error("slot bit count past length");

    property p_frame_start;
        @(posedge ref_clk) disable iff (srst)
        fstart |=> ((st_reg.bis == 6'h00 && st_reg.slot == 4'h0)
        || (st_reg.slot == 4'hF && st_reg.bis == slen - 6'(STD_MSB_OFFSET))) ##1 !rise;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame start not taken");

endmodule
`default_nettype wire

// ===== host_master.sv
// host-side serial master model: bit clock, word clock and receive data
`timescale 1ns/1ps
`default_nettype none
module host_master (
    // serial pins toward the port
    output logic bit_clock,
    output logic frame_word_clock,
    output logic serial_rx_data
);
    // the bit clock stands high between frames
    initial
    begin
        bit_clock = 1'b1;
        frame_word_clock = 1'b1;
        serial_rx_data = 1'b0;
    end
    // one frame with a lead-in and a trailing bit; same word in each slot, 200 ns per bit
    task automatic send_frame(input int fmt, tdm, n, len, pulse, wd, input logic [23:0] w);
        int d, vs, vb;
        for (int s = -1; s <= n; s++)
            for (int b = (s < 0) ? len - 1 : 0; b < ((s == n) ? 1 : len); b++)
            begin
                // standard framing runs its slots one bit behind the word clock
                vs = (fmt == 0 && b == 0) ? s - 1 : s;
                vb = (fmt == 0) ? ((b == 0) ? len - 1 : b - 1) : b;
                d = (fmt == 2) ? vb - (len - wd) : vb;
                bit_clock = 1'b0;
                if (tdm != 0)
                    frame_word_clock = (s == 0) && (pulse == 0 || b == 0);
                else
                    frame_word_clock = (s == 0) ^ (fmt == 0);
                // unused bits toggle so that a stale level is never mistaken for data
                if (vs >= 0 && vs < n && d >= 0 && d < wd)
                    serial_rx_data = (d < 24) ? w[23 - d] : 1'b0;
                else
                    serial_rx_data = ~serial_rx_data;
                #100; // data launched on the fall, held over the rise
                bit_clock = 1'b1;
                #100;
            end
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// testbench: random frames in all formats and slot counts, transmit pin and stall checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import audio_serial_pkg::*;
    logic ref_clk, srst, sample_out_ready, serial_tx_data, serial_tx_data_oe;
    logic sample_out_valid, rx_overrun;
    logic [23:0] sample_out;
    wire logic bit_clock, frame_word_clock, serial_rx_data;
    port_cfg_s port_cfg;
    dsp_cfg_s dsp_cfg;
    int mismatches = 0, n_checks = 0, pops = 0, ovr = 0, stall = 0;
    int slots_tab [5] = '{1, 2, 4, 6, 8};
    int len_tab [3] = '{16, 24, 32};
    int wid_tab [4] = '{16, 20, 24, 32};

    host_master u_host (.bit_clock(bit_clock), .frame_word_clock(frame_word_clock),
        .serial_rx_data(serial_rx_data));
    audio_serial_port_and_dsp_path dut (.ref_clk(ref_clk), .srst(srst), .bit_clock(bit_clock),
        .frame_word_clock(frame_word_clock), .serial_rx_data(serial_rx_data),
        .serial_tx_data(serial_tx_data), .serial_tx_data_oe(serial_tx_data_oe),
        .port_cfg(port_cfg), .dsp_cfg(dsp_cfg), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid), .sample_out_ready(sample_out_ready),
        .rx_overrun(rx_overrun));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // consumer pops at random; muted samples must come out as silence
    always @(posedge ref_clk)
    begin
        if (!srst && sample_out_valid && sample_out_ready)
        begin
            pops++;
            if (dsp_cfg.mute)
                check({8'h00, sample_out}, 32'h0);
        end
        if (!srst && rx_overrun)
            ovr++;
        #2;
        sample_out_ready = (stall == 0) && ($urandom_range(3) != 0);
    end

    // watchdog: about twice the longest expected run
    initial
    begin
        #2000000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        int fmt, tdm, k, n, j, ws, used, p0, exp_oe;
        void'($urandom(32'h147FD109));
        port_cfg = '0;
        port_cfg.sample_width_select = width_24;
        dsp_cfg = '1;
        dsp_cfg.volume_atten = 10'h000;
        dsp_cfg.eq_coef = '0;
        for (int e = 0; e < EQ_SECTIONS; e++)
            dsp_cfg.eq_coef[e][0] = 16'h4000;
        srst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #2 srst = 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            fmt = i % 3;
            tdm = (i >= 3);
            k = tdm ? $urandom_range(4) : 1;
            n = slots_tab[k];
            j = $urandom_range(2);
            // wider samples only fit the longer slots
            ws = (j == 0) ? 0 : $urandom_range(j + 1, 1);
            @(posedge ref_clk);
            #2;
            port_cfg.framing_format_select = framing_e'(fmt);
            port_cfg.tdm_mode = tdm[0];
            port_cfg.slot_count_select = slot_count_e'(k);
            port_cfg.slot_length_select = slot_len_e'(j);
            port_cfg.sample_width_select = sample_width_e'(ws);
            port_cfg.source_channel_select = source_chan_e'($urandom_range(2));
            port_cfg.input_half_level = 1'($urandom_range(1));
            port_cfg.tx_slot = 3'($urandom_range(n - 1));
            port_cfg.tx_output_enable = 1'($urandom_range(1));
            port_cfg.unused_slot_tristate = 1'($urandom_range(1));
            port_cfg.unused_slot_fill_select = 1'($urandom_range(1));
            dsp_cfg.mute = 1'($urandom_range(1));
            p0 = pops;
            u_host.send_frame(fmt, tdm, n, len_tab[j], $urandom_range(1), wid_tab[ws],
                24'($urandom));
            repeat (40) @(posedge ref_clk);
            check(32'(pops - p0), 32'h1);
            // the last fall points at slot 0, or at the last slot where standard framing lags
            used = (fmt == 0) ? n - 1 : 0;
            exp_oe = port_cfg.tx_output_enable
                && (port_cfg.tx_slot == used || !port_cfg.unused_slot_tristate);
            check({31'h0, serial_tx_data_oe}, 32'(exp_oe));
            if (exp_oe != 0 && port_cfg.tx_slot != used && !port_cfg.unused_slot_fill_select)
                check({31'h0, serial_tx_data}, 32'h0);
        end
        // consumer stalls over five frames: two entries, the held result and the pending
        // word survive, and the fifth frame overwrites the pending one
        stall = 1;
        ovr = 0;
        p0 = pops;
        repeat (5) u_host.send_frame(fmt, tdm, n, len_tab[j], 0, wid_tab[ws], 24'h5A5A5A);
        check(32'(ovr != 0), 32'h1);
        stall = 0;
        repeat (40) @(posedge ref_clk);
        check(32'(pops - p0), 32'h4);
        end_of_test();
    end
endmodule
`default_nettype wire
